// ---- core/i2c_slave_pkg.sv ----
// constants, modes and state type for the serial-port slave core
//
// Summary of operation
// - four-bit mode field picks 7-bit slave, 10-bit slave, master or firmware mode
// - master mode bus clock is core clock over four times (address plus one)
// - port pins and function are active only while the enable bit is set
// - start and stop are detected in hardware and reported as flags
// - short glitches on clock and data inputs are filtered; a new level passes only after FILT_CYCLES core cycles
// - status reports start, stop, data or address, address update, direction
// - shift register keeps receiving while finished bytes move to the buffer
// - a byte finishing before the buffer is read sets overflow and is lost
// - matched address or data byte is copied to the buffer, then acknowledged
// - no acknowledge when buffer-full or overflow was already set
// - byte into full buffer leaves buffer alone but sets interrupt and overflow
// - reading the buffer clears buffer-full; only software clears overflow
// - after start, eight bits shift in, each sampled on clock rising edge
// - shift bits seven to one are compared with the address at eighth fall
// - match loads buffer and full flag at eighth fall, interrupt at ninth fall
// - ten-bit first byte is recognised by top five bits, sent as write
// - ten-bit first byte is 11110, address bits nine and eight, write bit
// - matched ten-bit high and low address bytes after a first start set update flag and stretch clock
// - software reloads the high byte after the low match, releasing the clock
// - after repeated start in ten-bit mode only the high byte must match
// - as slave transmitter the core drives the data line with its own bits
// - overflow set with buffer empty loads the byte and interrupts, no acknowledge
// - reset releases both pins and drops any transfer in progress, leaving the enable bit as it is
package i2c_slave_pkg;

    // mode field encodings
    localparam logic [3:0] MODE_SLV7      = 4'h6;
    localparam logic [3:0] MODE_SLV10     = 4'h7;
    localparam logic [3:0] MODE_MSTR      = 4'h8;
    localparam logic [3:0] MODE_FIRMWARE  = 4'hb;

    // byte framing
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [4:0] TENB_HEADER    = 5'h1e;
    localparam int         MSTR_DIV_MULT  = 4;

    // glitch filter length in core cycles
    localparam int         FILT_LEN       = 3;

    // reset values
    localparam logic [7:0] ADDR_RST       = 8'h00;
    localparam logic [7:0] BUF_RST        = 8'h00;

    typedef enum logic [2:0] {
        st_idle,
        st_shift,
        st_ack,
        st_hold,
        st_tx,
        st_txack
    } slv_state_t;

endpackage

// ---- core/i2c_slave_core.sv ----
// serial-port core in bus slave role: start/stop, addressing, receive buffer
`timescale 1ns/10ps
`default_nettype none

module i2c_slave_core #(
    parameter int FILT_CYCLES = i2c_slave_pkg::FILT_LEN
) (
    input  wire logic                     mclk,
    input  wire logic                     srst,
    input  wire logic                     clk_en,
    input  wire logic                     scl_in,
    output logic                          scl_out,
    output logic                          scl_oe,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe,
    input  wire logic [3:0]               mode_sel,
    input  wire logic                     port_enable_bit,
    input  wire logic                     overflow_clr,
    input  wire logic                     irq_clr,
    input  wire logic                     addr_wr,
    input  wire logic [7:0]               addr_wdata,
    input  wire logic                     buf_rd,
    input  wire logic                     tx_wr,
    input  wire logic [7:0]               tx_wdata,
    input  wire logic                     clk_release,
    output logic [7:0]                    rx_tx_buffer,
    output logic [7:0]                    slave_address_reg,
    output logic                          buffer_full_flag,
    output logic                          overflow_flag,
    output logic                          port_irq_flag,
    output logic                          update_address_flag,
    output logic                          start_flag,
    output logic                          stop_flag,
    output logic                          data_flag,
    output logic                          rw_flag
);
    import i2c_slave_pkg::*;

    localparam int FCW = $clog2(FILT_CYCLES + 1);

    // ------------------------------------------------------------
    // pin synchronisers and glitch filters
    // ------------------------------------------------------------
    logic [1:0]  pin_raw;
    logic [1:0]  filt_w;
    logic        scl_f;
    logic        sda_f;
    logic        scl_p_q;
    logic        sda_p_q;

    assign pin_raw = {sda_in, scl_in};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic           sync1_q;
            logic           sync2_q;
            logic           filt_q;
            logic [FCW-1:0] fcnt_q;
            // two-flop sync, level must stay stable to pass
            always_ff @(posedge mclk) begin
                if (srst) begin
                    sync1_q <= 1'b1;
                    sync2_q <= 1'b1;
                    filt_q  <= 1'b1;
                    fcnt_q  <= '0;
                end else if (clk_en) begin
                    sync1_q <= pin_raw[g];
                    sync2_q <= sync1_q;
                    if (sync2_q == filt_q) begin
                        fcnt_q <= '0;
                    end else if (fcnt_q == FCW'(FILT_CYCLES - 1)) begin
                        filt_q <= sync2_q;
                        fcnt_q <= '0;
                    end else begin
                        fcnt_q <= fcnt_q + 1'b1;
                    end
                end
            end
            assign filt_w[g] = filt_q;
        end
    endgenerate

    assign scl_f = filt_w[0];
    assign sda_f = filt_w[1];

    // previous filtered levels for edge detection
    always_ff @(posedge mclk) begin
        if (srst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (clk_en) begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // ------------------------------------------------------------
    // bus events and mode decode
    // ------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic slave_on;
    logic ten_mode;
    logic mstr_on;

    assign scl_rise  = scl_f & ~scl_p_q;
    assign scl_fall  = ~scl_f & scl_p_q;
    // data edge while clock high marks start or stop
    assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    // mode field selects the role, only while enabled
    assign ten_mode  = (mode_sel == MODE_SLV10);
    assign slave_on  = port_enable_bit & ((mode_sel == MODE_SLV7) | ten_mode);
    assign mstr_on   = port_enable_bit & (mode_sel == MODE_MSTR);

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    slv_state_t st_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] sr_q;
    logic [7:0] addr_q;
    logic [7:0] buf_q;
    logic       addressed_q;
    logic       tenb_lo_q;
    logic       tenb_done_q;
    logic       ack_q;
    logic       ack_rx_q;
    logic       tx_loaded_q;
    logic       bf_q;
    logic       ovf_q;
    logic       irq_q;
    logic       ua_q;
    logic       start_q;
    logic       stop_q;
    logic       data_q;
    logic       rw_q;

    // ------------------------------------------------------------
    // address compare at the eighth falling edge
    // ------------------------------------------------------------
    logic eval;
    logic hi_match;
    logic match;
    logic ua_set;
    logic accept;
    logic ack_ok;
    logic load;

    assign eval     = (st_q == st_shift) & scl_fall & (bit_cnt_q == BYTE_BITS);
    // ten-bit header is 11110 plus two address bits
    assign hi_match = (sr_q[7:3] == TENB_HEADER) & (sr_q[7:1] == addr_q[7:1]);

    // compare shift bits 7:1, or the full low byte in ten-bit mode
    always_comb begin
        match  = 1'b0;
        ua_set = 1'b0;
        if (!ten_mode) begin
            match = (sr_q[7:1] == addr_q[7:1]);
        end else if (tenb_lo_q) begin
            match  = (sr_q == addr_q);
            ua_set = 1'b1;
        end else if (tenb_done_q) begin
            // repeated start needs only the high byte
            match = hi_match;
        end else begin
            // first byte must carry write direction
            match  = hi_match & ~sr_q[0];
            ua_set = 1'b1;
        end
    end

    assign accept = addressed_q | match;
    // no acknowledge when either flag already set
    assign ack_ok = accept & ~bf_q & ~ovf_q;
    // overflow alone still lets the byte in
    assign load   = accept & ~bf_q;

    // ------------------------------------------------------------
    // transfer state machine
    // ------------------------------------------------------------
    // reset or disable drops the transfer
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q        <= st_idle;
            bit_cnt_q   <= 4'h0;
            sr_q        <= 8'h00;
            addressed_q <= 1'b0;
            tenb_lo_q   <= 1'b0;
            tenb_done_q <= 1'b0;
            ack_q       <= 1'b0;
            ack_rx_q    <= 1'b0;
            tx_loaded_q <= 1'b0;
        end else if (clk_en) begin
            if (!slave_on || stop_det) begin
                st_q        <= st_idle;
                addressed_q <= 1'b0;
                tenb_lo_q   <= 1'b0;
                tenb_done_q <= 1'b0;
                ack_q       <= 1'b0;
                tx_loaded_q <= 1'b0;
            end else if (start_det) begin
                // every start, repeated or not, begins an address byte
                st_q        <= st_shift;
                bit_cnt_q   <= 4'h0;
                addressed_q <= 1'b0;
                tenb_lo_q   <= 1'b0;
                ack_q       <= 1'b0;
                tx_loaded_q <= 1'b0;
            end else begin
                case (st_q)
                    st_idle: begin
                        bit_cnt_q <= 4'h0;
                    end
                    st_shift: begin
                        // sample on rising clock, MSB first
                        if (scl_rise && bit_cnt_q != BYTE_BITS) begin
                            sr_q      <= {sr_q[6:0], sda_f};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (eval) begin
                            st_q  <= accept ? st_ack : st_idle;
                            ack_q <= ack_ok;
                            if (!addressed_q && match) begin
                                if (ten_mode && !tenb_lo_q && !tenb_done_q) begin
                                    tenb_lo_q <= 1'b1;
                                end else begin
                                    addressed_q <= 1'b1;
                                    tenb_lo_q   <= 1'b0;
                                    tenb_done_q <= ten_mode;
                                end
                            end
                        end
                    end
                    st_ack: begin
                        // release acknowledge at the ninth fall
                        if (scl_fall) begin
                            ack_q     <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            if (ua_q || (addressed_q && rw_q)) begin
                                st_q <= st_hold;
                            end else begin
                                st_q <= st_shift;
                            end
                        end
                    end
                    st_hold: begin
                        if (tx_wr) begin
                            sr_q        <= tx_wdata;
                            tx_loaded_q <= 1'b1;
                        end
                        if (ua_q && addr_wr) begin
                            st_q <= st_shift;
                        end else if (!ua_q && tx_loaded_q && clk_release) begin
                            st_q      <= st_tx;
                            bit_cnt_q <= 4'h0;
                        end
                    end
                    st_tx: begin
                        // shift out on each falling clock
                        if (scl_fall) begin
                            sr_q      <= {sr_q[6:0], 1'b1};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == BYTE_BITS - 4'h1) begin
                                st_q <= st_txack;
                            end
                        end
                    end
                    st_txack: begin
                        if (scl_rise) begin
                            ack_rx_q <= ~sda_f;
                        end else if (scl_fall) begin
                            tx_loaded_q <= 1'b0;
                            st_q        <= ack_rx_q ? st_hold : st_idle;
                        end
                    end
                    default: begin
                        st_q <= st_idle;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // buffer, address register and status flags
    // ------------------------------------------------------------
    logic ninth_fall;

    assign ninth_fall = ((st_q == st_ack) | (st_q == st_txack)) & scl_fall & slave_on & ~start_det & ~stop_det;

    // finished byte moves to the buffer, at the eighth fall
    always_ff @(posedge mclk) begin
        if (srst) begin
            buf_q <= BUF_RST;
        end else if (clk_en) begin
            if (eval && load && slave_on && !start_det && !stop_det) begin
                buf_q <= sr_q;
            end else if (tx_wr && st_q == st_hold) begin
                buf_q <= tx_wdata;
            end
        end
    end

    // address register written by software
    always_ff @(posedge mclk) begin
        if (srst) begin
            addr_q <= ADDR_RST;
        end else if (clk_en && addr_wr) begin
            addr_q <= addr_wdata;
        end
    end

    // sticky flags: hardware set wins over software clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            bf_q  <= 1'b0;
            ovf_q <= 1'b0;
            irq_q <= 1'b0;
            ua_q  <= 1'b0;
        end else if (clk_en) begin
            if (eval && load && slave_on && !start_det && !stop_det) begin
                bf_q <= 1'b1;
            end else if (buf_rd) begin
                bf_q <= 1'b0;
            end
            // byte into full buffer sets overflow, cleared only by software
            if (eval && accept && bf_q && slave_on && !start_det && !stop_det) begin
                ovf_q <= 1'b1;
            end else if (overflow_clr) begin
                ovf_q <= 1'b0;
            end
            if (ninth_fall) begin
                irq_q <= 1'b1;
            end else if (irq_clr) begin
                irq_q <= 1'b0;
            end
            // matched ten-bit high or low address byte after a first start asks for an address update
            if (eval && match && !addressed_q && ua_set && slave_on && !start_det && !stop_det) begin
                ua_q <= 1'b1;
            end else if (addr_wr || !slave_on) begin
                ua_q <= 1'b0;
            end
        end
    end

    // status: start/stop, data or address, direction
    always_ff @(posedge mclk) begin
        if (srst) begin
            start_q <= 1'b0;
            stop_q  <= 1'b0;
            data_q  <= 1'b0;
            rw_q    <= 1'b0;
        end else if (clk_en) begin
            if (!port_enable_bit) begin
                start_q <= 1'b0;
                stop_q  <= 1'b0;
            end else if (start_det) begin
                start_q <= 1'b1;
                stop_q  <= 1'b0;
            end else if (stop_det) begin
                start_q <= 1'b0;
                stop_q  <= 1'b1;
            end
            if (eval && accept && slave_on) begin
                data_q <= addressed_q;
                if (!addressed_q && match && !ua_set) begin
                    rw_q <= sr_q[0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // master clock generator
    // ------------------------------------------------------------
    logic [9:0] div_cnt_q;
    logic       mstr_scl_q;
    logic [9:0] half_w;

    // period is MSTR_DIV_MULT * (address + 1) core cycles
    assign half_w = 10'((MSTR_DIV_MULT / 2) * (int'(addr_q) + 1));

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt_q  <= 10'h000;
            mstr_scl_q <= 1'b1;
        end else if (clk_en) begin
            if (!mstr_on) begin
                div_cnt_q  <= 10'h000;
                mstr_scl_q <= 1'b1;
            end else if (div_cnt_q == half_w - 10'h001) begin
                div_cnt_q  <= 10'h000;
                mstr_scl_q <= ~mstr_scl_q;
            end else begin
                div_cnt_q <= div_cnt_q + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers and outputs
    // ------------------------------------------------------------
    // pins driven only while enabled; open drain pulls low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = (slave_on & (st_q == st_hold)) | (mstr_on & ~mstr_scl_q);
    assign sda_oe  = slave_on & (((st_q == st_ack) & ack_q) |
                     (((st_q == st_tx) | ((st_q == st_hold) & tx_loaded_q)) & ~sr_q[7]));

    assign rx_tx_buffer        = buf_q;
    assign slave_address_reg   = addr_q;
    assign buffer_full_flag    = bf_q;
    assign overflow_flag       = ovf_q;
    assign port_irq_flag       = irq_q;
    assign update_address_flag = ua_q;
    assign start_flag          = start_q;
    assign stop_flag           = stop_q;
    assign data_flag           = data_q;
    assign rw_flag             = rw_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic good_eval;
    assign good_eval = clk_en & eval & slave_on & ~start_det & ~stop_det;

    sequence ninth_edge_s;
        clk_en && ninth_fall;
    endsequence

    sequence ua_release_s;
        clk_en && slave_on && st_q == st_hold && ua_q && addr_wr && !start_det && !stop_det;
    endsequence

    buffer_load_a: assert property (good_eval && load |=> bf_q && buf_q == $past(sr_q))
        else $error("matched byte not loaded into buffer");
    overflow_keep_a: assert property (good_eval && accept && bf_q |=> ovf_q && buf_q == $past(buf_q))
        else $error("byte into full buffer mishandled");
    ack_withheld_a: assert property (good_eval && accept && (bf_q || ovf_q) |=> !ack_q)
        else $error("acknowledge given with flag set");
    ack_given_a: assert property (good_eval && ack_ok |=> ack_q && sda_oe)
        else $error("acknowledge not driven");
    irq_ninth_a: assert property (ninth_edge_s |=> irq_q && !ack_q)
        else $error("ninth fall did not interrupt and release");
    ovf_sticky_a: assert property (ovf_q && !overflow_clr |=> ovf_q)
        else $error("overflow cleared without software");
    ua_release_a: assert property (ua_release_s |=> !ua_q && st_q == st_shift && !scl_oe)
        else $error("address update did not release clock");
    disabled_pins_a: assert property (!port_enable_bit |-> !sda_oe && !scl_oe)
        else $error("pin driven while disabled");
    start_seen_a: assert property (clk_en && port_enable_bit && start_det |=> start_q && !stop_q)
        else $error("start not flagged");
    bf_clear_a: assert property (clk_en && buf_rd && !good_eval |=> !bf_q)
        else $error("buffer read did not clear full");

endmodule

`default_nettype wire

// ---- verif/i2c_bus_master_model.sv ----
// behavioural bus master driving open-drain clock and data lines
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_master_model (
    input  wire logic mclk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_pull,
    output logic      sda_pull,
    output logic      timed_out
);
    localparam int HALF = 12;

    // data bits seen on the line at each clock high, msb first
    logic [7:0] got;

    // lines released at time zero, pull-ups take them high
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        timed_out = 1'b0;
        got = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // release clock, then wait while the slave stretches it
    task automatic rise();
        int i;
        scl_pull <= 1'b0;
        for (i = 0; i < 2000 && scl !== 1'b1; i++) @(posedge mclk);
        if (i == 2000) timed_out <= 1'b1;
        hold(HALF);
    endtask

    task automatic fall();
        scl_pull <= 1'b1;
        hold(HALF);
    endtask

    // data falls while clock is high, also serves as repeated start
    task automatic start();
        sda_pull <= 1'b0;
        hold(HALF);
        rise();
        sda_pull <= 1'b1;
        hold(HALF);
        fall();
    endtask

    // data rises while clock is high
    task automatic stop();
        sda_pull <= 1'b1;
        hold(HALF);
        rise();
        sda_pull <= 1'b0;
        hold(HALF);
    endtask

    // msb first, data changes only while clock is low
    task automatic send(input logic [7:0] b, output logic ack);
        for (int k = 7; k >= 0; k--) begin
            sda_pull <= ~b[k];
            hold(HALF);
            rise();
            got = {got[6:0], sda};
            fall();
        end
        sda_pull <= 1'b0;
        hold(HALF);
        rise();
        ack = ~sda;
        fall();
    endtask
endmodule

`default_nettype wire

// ---- verif/test_i2c_slave_address_receive.sv ----
// self-checking bench for the slave address and receive core
`timescale 1ns/10ps
`default_nettype none

module test_i2c_slave_address_receive;
    import i2c_slave_pkg::*;
    typedef struct packed {logic [3:0] mode; logic [7:0] adr; logic [7:0] b; logic ack; logic ua;} row_t;
    logic mclk = 0, srst = 1, port_enable_bit = 0, buf_rd = 0, irq_clr = 0, overflow_clr = 0, addr_wr = 0, ack;
    logic [3:0] mode_sel = MODE_SLV7;
    logic tx_wr = 0, clk_release = 0;
    logic [7:0] tx_wdata = 8'h00;
    int n_lo;
    logic [7:0] addr_wdata = 8'h00, rx_tx_buffer, slave_address_reg;
    logic scl_oe, sda_oe, m_scl, m_sda, m_to, buffer_full_flag, overflow_flag, port_irq_flag;
    logic update_address_flag, start_flag, stop_flag, data_flag, rw_flag;
    wire logic scl = ~(scl_oe | m_scl);
    wire logic sda = ~(sda_oe | m_sda);
    int n_mismatch = 0, check_count = 0;
    row_t rows [6] = '{'{MODE_SLV7, 8'h54, 8'h54, 1'b1, 1'b0}, '{MODE_SLV7, 8'h54, 8'h56, 1'b0, 1'b0},
        '{MODE_SLV7, 8'h54, 8'hd4, 1'b0, 1'b0}, '{MODE_FIRMWARE, 8'h54, 8'h54, 1'b0, 1'b0},
        '{MODE_SLV10, 8'hf2, 8'hf2, 1'b1, 1'b1}, '{MODE_SLV10, 8'hf2, 8'hf6, 1'b0, 1'b0}};

    always #20 mclk = ~mclk;

    i2c_slave_core #(.FILT_CYCLES(1)) dut (.mclk(mclk), .srst(srst), .clk_en(1'b1), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .mode_sel(mode_sel),
        .port_enable_bit(port_enable_bit), .overflow_clr(overflow_clr), .irq_clr(irq_clr), .addr_wr(addr_wr),
        .addr_wdata(addr_wdata), .buf_rd(buf_rd), .tx_wr(tx_wr), .tx_wdata(tx_wdata), .clk_release(clk_release),
        .rx_tx_buffer(rx_tx_buffer), .slave_address_reg(slave_address_reg), .buffer_full_flag(buffer_full_flag),
        .overflow_flag(overflow_flag), .port_irq_flag(port_irq_flag), .update_address_flag(update_address_flag),
        .start_flag(start_flag), .stop_flag(stop_flag), .data_flag(data_flag), .rw_flag(rw_flag));
    i2c_bus_master_model m (.mclk(mclk), .scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda), .timed_out(m_to));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    // one-cycle software strobes {buf_rd, irq_clr, overflow_clr, addr_wr}
    task automatic sw(input logic [3:0] s, input logic [7:0] a);
        @(posedge mclk);
        {buf_rd, irq_clr, overflow_clr, addr_wr} <= s;
        addr_wdata <= a;
        @(posedge mclk);
        {buf_rd, irq_clr, overflow_clr, addr_wr} <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge m_to) begin
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        port_enable_bit <= 1'b1;
        check(rx_tx_buffer, BUF_RST);
        for (int r = 0; r < 6; r++) begin
            mode_sel <= rows[r].mode;
            sw(4'hf, rows[r].adr);
            m.start();
            check(start_flag, 1'b1);
            m.send(rows[r].b, ack); // address byte or ten-bit header, sent as write
            check(ack, rows[r].ack);
            check(buffer_full_flag, rows[r].ack);
            check(port_irq_flag, rows[r].ack);
            check(update_address_flag, rows[r].ua);
            if (rows[r].ack) check(rx_tx_buffer, rows[r].b);
            sw(4'h1, rows[r].adr);
            m.stop();
            check(stop_flag, 1'b1);
            $display("row %0d done", r);
        end
        // overflow: byte into full buffer, then into empty buffer with overflow still set
        mode_sel <= MODE_SLV7;
        sw(4'hf, 8'h54);
        m.start();
        m.send(8'h54, ack);
        m.send(8'ha5, ack);
        check(ack, 1'b0);
        check({overflow_flag, port_irq_flag, rx_tx_buffer}, {2'b11, 8'h54});
        sw(4'h8, 8'h54);
        check({buffer_full_flag, overflow_flag}, 2'b01);
        m.send(8'h3c, ack);
        check({ack, buffer_full_flag, rx_tx_buffer, data_flag}, {2'b01, 8'h3c, 1'b1});
        m.stop();
        sw(4'h2, 8'h54);
        check(overflow_flag, 1'b0);
        $display("overflow test done");
        // ten-bit: high, low, repeated start with high byte only, then reset mid-transfer
        mode_sel <= MODE_SLV10;
        sw(4'hf, 8'hf2);
        m.start();
        m.send(8'hf2, ack);
        check({scl_oe, update_address_flag}, 2'b11);
        sw(4'hf, 8'h35);
        check(update_address_flag, 1'b0);
        m.send(8'h35, ack);
        check({ack, update_address_flag, rx_tx_buffer}, {2'b11, 8'h35});
        // reload high byte after low match
        sw(4'hf, 8'hf2);
        m.start();
        m.send(8'hf3, ack);
        check({ack, buffer_full_flag, update_address_flag, rw_flag}, 4'b1101);
        // slave transmit: load a byte, release the stretch, master reads it and answers not-ack
        tx_wdata <= 8'ha6;
        tx_wr <= 1'b1;
        @(posedge mclk);
        tx_wr <= 1'b0;
        clk_release <= 1'b1;
        @(posedge mclk);
        clk_release <= 1'b0;
        m.send(8'hff, ack);
        check({m.got, ack}, {8'ha6, 1'b0});
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        check({scl_oe, sda_oe, buffer_full_flag, port_irq_flag, rx_tx_buffer}, {4'b0000, BUF_RST});
        m.stop();
        $display("ten-bit and reset test done");
        // master mode: clock low phase is half of MSTR_DIV_MULT * (address + 1) cycles
        sw(4'h1, 8'h02);
        mode_sel <= MODE_MSTR;
        n_lo = 0;
        for (int i = 0; i < 40 && !scl_oe; i++) @(posedge mclk);
        while (scl_oe && n_lo < 40) begin
            @(posedge mclk);
            n_lo++;
        end
        check(16'(n_lo), 16'(MSTR_DIV_MULT * 3 / 2));
        $display("master clock test done");
        test_done();
    end
endmodule

`default_nettype wire
